// ---- dv/highres_status_monitor.sv ----
// Checker for the status bank, watching only its ports.
// Assumes the bind below attaches it to every bank instance.
`include "highres_status_defines.svh"
module highres_status_monitor
(
    input wire logic                            clk_i,
    input wire logic                            rst_i,
    input wire highres_status_pkg::conversion_t conv_i,
    input wire logic [7:0]                      addr_i,
    input wire logic [7:0]                      wdata_i,
    input wire logic                            wr_i,
    input wire logic                            rd_i,
    input wire logic [7:0]                      rdata_o,
    input wire logic                            irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reads with no conversion beside them, so the outcome is unambiguous
    wire r38 = rd_i && addr_i == 8'h38 && !conv_i.valid;
    wire r3b = rd_i && addr_i == 8'h3B && !conv_i.valid;
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Conversion, gap, low-byte read, status read
    sequence s_fresh;
        conv_i.valid ##1 !conv_i.valid ##1 r38 ##1 r3b;
    endsequence
    AST_ID_REV: assert property (rd_i && addr_i == 8'h3E |=> rdata_o == {`PART_IDENTITY_VAL, `REVISION_VAL})
        else $error("identity read wrong");
    AST_FAMILY: assert property (rd_i && addr_i == 8'h3F |=> rdata_o == `FAMILY_CODE_VAL)
        else $error("family read wrong");
    AST_UNUSED_ZERO: assert property (rd_i && addr_i == 8'h3B |=> rdata_o[7:5] == 3'h0)
        else $error("unused status bits set");
    AST_PEND_SET: assert property (conv_i.valid ##1 (rd_i && addr_i == 8'h3B) |=> !rdata_o[0])
        else $error("pending flag not low");
    AST_PEND_CLR: assert property (r38 ##1 r3b |=> rdata_o[0])
        else $error("pending flag not released");
    AST_UNDER: assert property (s_fresh |=> rdata_o[2] == $past(conv_i.under_range, 4))
        else $error("under-range flag wrong");
    AST_OVF: assert property (s_fresh |=> rdata_o[1] == $past(conv_i.overflow, 4))
        else $error("overflow flag wrong");
    AST_ZERO: assert property (s_fresh |=> rdata_o[4] == $past(conv_i.zero_count, 4))
        else $error("zero-count flag wrong");
    AST_ORNG: assert property (s_fresh |=> rdata_o[3] == $past(conv_i.over_range, 4))
        else $error("over-range flag wrong");
endmodule
bind highres_status_regs highres_status_monitor u_mon
(
    .clk_i, .rst_i, .conv_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o
);

// ---- dv/host_model.sv ----
// Host model: puts each order onto the register port one cycle later.
// Assumes orders arrive by non-blocking assignment after a rising edge.
module host_model
(
    input  wire logic                         clk_i, // System clock
    input  wire logic                         rst_i, // Sync reset, high
    input  wire highres_status_pkg::reg_req_t req_i, // Next bus cycle
    output highres_status_pkg::reg_req_t      bus_o  // Register port
);
    timeunit 1ns;
    timeprecision 1ps;
    // Orders leave in issue order, result bytes low first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bus_o <= '0;
        else if (req_i.wr || req_i.rd)
            bus_o <= req_i;
        // Idle lines toggle so a stale value never looks valid
        else
            bus_o <= '{addr: ~bus_o.addr, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b0};
    end
endmodule

// ---- dv/tb_top.sv ----
// Testbench for the status bank; the host model drives its register port.
// Assumes the design's constants header and a 25 MHz clock.
`include "highres_status_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                            clk_i;   // 25 MHz clock
    logic                            rst_i;   // Sync reset
    highres_status_pkg::conversion_t conv;    // Core output
    highres_status_pkg::reg_req_t    req;     // Order to host
    highres_status_pkg::reg_req_t    bus;     // Host bus
    logic [7:0]                      rdata;   // Read data
    logic                            irq;     // Interrupt
    logic                            rd_d;    // Read taken next edge
    logic [7:0]                      exp_q[$];
    logic [3:0]                      fl;      // Flags last read
    logic [3:0]                      nf;      // New random flags
    logic [23:0]                     code;    // Random result
    logic                            err_any; // Some result carried an error
    int                              miscompares;
    int                              checks;
    int                              cycles;
    host_model u_host (.clk_i, .rst_i, .req_i(req), .bus_o(bus));
    highres_status_regs u_dut (.clk_i, .rst_i, .conv_i(conv), .addr_i(bus.addr), .wdata_i(bus.wdata),
                               .wr_i(bus.wr), .rd_i(bus.rd), .rdata_o(rdata), .irq_o(irq));
    // Clock, 40 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One bus cycle; a read notes its expected data
    task op(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        if (!w)
            exp_q.push_back(d);
        @(posedge clk_i);
    endtask
    // Answers sampled mid-cycle, well clear of the edge; also the hang limit
    always @(negedge clk_i)
    begin
        if (rd_d)
            check("rdata", rdata, exp_q.pop_front());
        rd_d = bus.rd;
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    initial
    begin
        conv = '0;
        req = '0;
        rd_d = 1'b0;
        cycles = 0;
        miscompares = 0;
        checks = 0;
        fl = 4'h0;
        err_any = 1'b0;
        rst_i = 1'b1;
        code = 24'($urandom(41));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        op(0, 8'h3B, 8'h01);
        op(1, 8'h3E, 8'h00);
        op(1, 8'h3F, 8'h00);
        op(0, 8'h3E, {`PART_IDENTITY_VAL, `REVISION_VAL});
        op(0, 8'h3F, `FAMILY_CODE_VAL);
        op(0, 8'h77, 8'h00);
        // Random results, read low byte first, status around it
        for (int i = 0; i < 8; i++)
        begin
            code = 24'($urandom);
            nf = 4'($urandom);
            conv <= {1'b1, code, nf};
            op(0, 8'h3B, {3'h0, fl, 1'b0});
            conv.valid <= 1'b0;
            op(0, 8'h38, code[7:0]);
            op(0, 8'h3B, {3'h0, nf, 1'b1});
            op(0, 8'h3B, {3'h0, nf, 1'b1});
            op(0, 8'h39, code[15:8]);
            op(0, 8'h3A, code[23:16]);
            op(1, 8'h3B, 8'hFF);
            fl = nf;
            err_any = err_any | (|nf);
        end
        // Sticky events from the loop: done always, error if any flag came, no loss
        op(0, 8'h40, {5'h00, 1'b0, err_any, 1'b1});
        // Interrupt: raise, overwrite unread, mask, clear
        op(1, 8'h40, 8'hFF);
        op(1, 8'h41, 8'h07);
        req <= '0;
        conv <= {1'b1, code, 4'h0};
        @(posedge clk_i);
        conv.valid <= 1'b0;
        @(posedge clk_i);
        conv.valid <= 1'b1;
        @(posedge clk_i);
        conv.valid <= 1'b0;
        repeat (2) @(negedge clk_i);
        check("irq", {7'h00, irq}, 8'h01);
        @(posedge clk_i);
        op(1, 8'h41, 8'h00);
        req <= '0;
        repeat (3) @(negedge clk_i);
        check("irq", {7'h00, irq}, 8'h00);
        @(posedge clk_i);
        op(0, 8'h40, 8'h05);
        op(1, 8'h40, 8'hFF);
        op(0, 8'h40, 8'h00);
        req <= '0;
        repeat (3) @(posedge clk_i);
        wrap_up();
    end
endmodule

// ---- verilog/highres_status_defines.svh ----
// Register offsets, field positions, reset values and fixed codes for the
// high-resolution status and identity bank. Assumes a plain byte-wide register port.
`ifndef HIGHRES_STATUS_DEFINES_SVH
`define HIGHRES_STATUS_DEFINES_SVH

// Register offsets (byte addresses)
`define RESULT_LOW_ADDR     8'h38
`define RESULT_MID_ADDR     8'h39
`define RESULT_HIGH_ADDR    8'h3A
`define STATUS_ADDR         8'h3B
`define REVISION_ID_ADDR    8'h3E
`define FAMILY_ID_ADDR      8'h3F
`define IRQ_STATUS_ADDR     8'h40
`define IRQ_MASK_ADDR       8'h41

// Status field positions
`define PENDING_BIT         0
`define OVERFLOW_BIT        1
`define UNDERRANGE_BIT      2
`define OVERRANGE_BIT       3
`define ZERO_COUNT_BIT      4

// Reset values
`define STATUS_RESET        8'h01
`define RESULT_RESET        24'h00_0000

// Identity codes, values arbitrary
`define PART_IDENTITY_VAL   5'h15
`define REVISION_VAL        3'h5
`define FAMILY_CODE_VAL     8'h5A

// Interrupt status bit positions
`define IRQ_CONV_BIT        0
`define IRQ_ERROR_BIT       1
`define IRQ_LOST_BIT        2

`endif

// ---- verilog/highres_status_pkg.sv ----
// Types shared by the high-resolution status bank and its helpers.
// Assumes the constants header supplies offsets and codes.
package highres_status_pkg;

    // One finished conversion from the core
    typedef struct packed {
        logic        valid;       // One-cycle strobe
        logic [23:0] code;        // Result code
        logic        zero_count;  // No sensor cycles seen
        logic        over_range;  // Sensor above reference
        logic        under_range; // Negative output code
        logic        overflow;    // Sensor too close to reference
    } conversion_t;

    // Error flag group
    typedef struct packed {
        logic zero_count;
        logic over_range;
        logic under_range;
        logic overflow;
    } err_flags_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// ---- verilog/highres_status_regs.sv ----
// Status, result and identity register bank of the high-resolution path.
// Assumes the converter core on the same clock supplies one-cycle conversion strobes.
`include "highres_status_defines.svh"

module highres_status_regs
(
    input  wire logic                               clk_i,    // System clock, 25 MHz
    input  wire logic                               rst_i,    // Synchronous reset, high
    input  wire highres_status_pkg::conversion_t    conv_i,   // Finished conversion from core
    input  wire logic [7:0]                         addr_i,   // Register address
    input  wire logic [7:0]                         wdata_i,  // Write data
    input  wire logic                               wr_i,     // Write strobe
    input  wire logic                               rd_i,     // Read strobe
    output logic [7:0]                              rdata_o,  // Read data, cycle after strobe
    output logic                                    irq_o     // Level interrupt
);

    localparam int NUM_IRQ = 3; // Conversion, error, lost result

    // Module state apart from the sticky interrupt bits
    typedef struct packed {
        logic [23:0]                     pending_code;  // Latest unread conversion
        highres_status_pkg::err_flags_t  pending_err;   // Its error flags
        logic [23:0]                     shown_code;    // Result snapshot seen by host
        highres_status_pkg::err_flags_t  shown_err;     // Flags of last result read
        logic                            pending_n;     // Low while unread result waits
        logic [NUM_IRQ-1:0]              irq_mask;      // Interrupt enables
        logic [7:0]                      rdata;         // Read data register
        logic                            irq;           // Registered interrupt
    } state_t;

    state_t cur;
    state_t next_cur;

    highres_status_pkg::reg_req_t req;  // Bundled bus request
    logic [NUM_IRQ-1:0]           irq_set;   // Event pulses
    logic [NUM_IRQ-1:0]           irq_clr;   // Write-one-to-clear pulses
    logic [NUM_IRQ-1:0]           irq_flags; // Sticky status
    logic                         low_read;  // Read of the low result byte
    logic                         any_err;   // New conversion carries an error

    assign req.addr  = addr_i;
    assign req.wdata = wdata_i;
    assign req.wr    = wr_i;
    assign req.rd    = rd_i;

    // Reading the low byte hands the pending result to the host
    assign low_read = req.rd && (req.addr == `RESULT_LOW_ADDR);

    assign any_err = conv_i.zero_count | conv_i.over_range | conv_i.under_range | conv_i.overflow;

    // Interrupt events
    always_comb
    begin
        irq_set = '0;
        irq_set[`IRQ_CONV_BIT]  = conv_i.valid;
        irq_set[`IRQ_ERROR_BIT] = conv_i.valid & any_err;
        // A new result over an unread one loses the older one
        irq_set[`IRQ_LOST_BIT]  = conv_i.valid & ~cur.pending_n & ~low_read;
    end

    // Write-one-to-clear decode
    always_comb
    begin
        irq_clr = '0;
        if (req.wr && (req.addr == `IRQ_STATUS_ADDR))
            irq_clr = req.wdata[NUM_IRQ-1:0];
    end

    // One sticky bit per event
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++)
        begin : g_irq
            sticky_flag u_flag
            (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .set_i   (irq_set[gi]),
                .clear_i (irq_clr[gi]),
                .flag_o  (irq_flags[gi])
            );
        end
    endgenerate

    // Next-state logic
    always_comb
    begin
        next_cur = cur;

        // Capture each finished conversion with its own error flags
        if (conv_i.valid)
        begin
            next_cur.pending_code            = conv_i.code;
            next_cur.pending_err.zero_count  = conv_i.zero_count;
            next_cur.pending_err.over_range  = conv_i.over_range;
            next_cur.pending_err.under_range = conv_i.under_range;
            next_cur.pending_err.overflow    = conv_i.overflow;
        end

        // Low byte read: snapshot result and flags together so the mid and
        // high bytes stay coherent with it; the host must read low first
        if (low_read)
        begin
            next_cur.shown_code = cur.pending_code;
            next_cur.shown_err  = cur.pending_err;
        end

        // Pending flag: conversion end wins over a read in the same cycle
        if (conv_i.valid)
            next_cur.pending_n = 1'b0;
        else if (low_read)
            next_cur.pending_n = 1'b1;

        // Only the mask stores written data; interrupt status is write-one-to-clear; status and identity ignore writes
        if (req.wr && (req.addr == `IRQ_MASK_ADDR))
            next_cur.irq_mask = req.wdata[NUM_IRQ-1:0];

        // Read mux; the low byte returns the value it is snapshotting
        next_cur.rdata = 8'h00;
        if (req.rd)
        begin
            unique case (req.addr)
                `RESULT_LOW_ADDR:
                    next_cur.rdata = cur.pending_code[7:0];
                `RESULT_MID_ADDR:
                    next_cur.rdata = cur.shown_code[15:8];
                `RESULT_HIGH_ADDR:
                    next_cur.rdata = cur.shown_code[23:16];
                `STATUS_ADDR:
                begin
                    // Upper three bits read zero
                    next_cur.rdata = 8'h00;
                    next_cur.rdata[`ZERO_COUNT_BIT] = cur.shown_err.zero_count;
                    next_cur.rdata[`OVERRANGE_BIT]  = cur.shown_err.over_range;
                    next_cur.rdata[`UNDERRANGE_BIT] = cur.shown_err.under_range;
                    next_cur.rdata[`OVERFLOW_BIT]   = cur.shown_err.overflow;
                    next_cur.rdata[`PENDING_BIT]    = cur.pending_n;
                end
                `REVISION_ID_ADDR:
                    next_cur.rdata = {`PART_IDENTITY_VAL, `REVISION_VAL};
                `FAMILY_ID_ADDR:
                    next_cur.rdata = `FAMILY_CODE_VAL;
                `IRQ_STATUS_ADDR:
                    next_cur.rdata = {5'h00, irq_flags};
                `IRQ_MASK_ADDR:
                    next_cur.rdata = {5'h00, cur.irq_mask};
                default:
                    // Unmapped addresses read zero
                    next_cur.rdata = 8'h00;
            endcase
        end

        // Interrupt high while any unmasked sticky bit is set
        next_cur.irq = |(irq_flags & cur.irq_mask);
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur              <= '0;
            cur.pending_n    <= 1'b1;  // No unread result after reset
            cur.pending_code <= `RESULT_RESET;
            cur.shown_code   <= `RESULT_RESET;
        end
        else
            cur <= next_cur;
    end

    // Outputs straight from flip-flops
    assign rdata_o = cur.rdata;
    assign irq_o   = cur.irq;

endmodule

// ---- verilog/sticky_flag.sv ----
// One sticky event bit: set by hardware, cleared by a one written by software.
// Assumes event and clear arrive on clk_i; set wins over clear.
module sticky_flag
(
    input  wire logic clk_i,    // System clock
    input  wire logic rst_i,    // Synchronous reset, high
    input  wire logic set_i,    // Event pulse
    input  wire logic clear_i,  // Write-one-to-clear
    output logic      flag_o    // Sticky state
);

    typedef struct packed {
        logic flag;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Set beats a clear in the same cycle so no event is lost
    always_comb
    begin
        next_cur = cur;
        if (set_i)
            next_cur.flag = 1'b1;
        else if (clear_i)
            next_cur.flag = 1'b0;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign flag_o = cur.flag;

endmodule
